// *** dv/tmds_regen_config_and_prbs_check_tb_top.sv ***
`timescale 1ns/1ps
module tmds_regen_config_and_prbs_check_tb_top;
  logic       core_clk = 1'b0;
  logic       nrst;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [1:0] sel_chan;
  logic [2:0] rx_data;
  logic [2:0] tx_data_p;
  logic [2:0] tx_data_n;
  logic [2:0] preemph_on;
  logic       tx_data_oe_n;
  logic       tx_clk_p;
  logic       tx_clk_n;
  logic       tx_clk_oe_n;
  logic [3:0] data_term_sel;
  logic [3:0] clk_term_sel;
  logic [3:0] drive_code;
  logic [3:0] preemph_code;
  logic [15:0] eq_gain;
  logic [1:0] loop_bw_sel;
  int         n_mismatch = 0;
  int         n_checks = 0;
  logic [7:0] d;
  // 125 MHz lies inside the pattern clock range
  always #4 core_clk = ~core_clk;
  tmdsrg_regs i_tmdsrg_regs (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sel_chan(sel_chan),
    .rx_data(rx_data), .tx_data_p(tx_data_p), .tx_data_n(tx_data_n), .tx_data_oe_n(tx_data_oe_n),
    .tx_clk_p(tx_clk_p), .tx_clk_n(tx_clk_n), .tx_clk_oe_n(tx_clk_oe_n), .preemph_on(preemph_on),
    .data_term_sel(data_term_sel), .clk_term_sel(clk_term_sel), .drive_code(drive_code),
    .preemph_code(preemph_code), .eq_gain(eq_gain), .loop_bw_sel(loop_bw_sel));
  tmdsrg_host i_tmdsrg_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset();
    logic [7:0] a[7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h10};
    logic [7:0] e[7] = '{8'h00, 8'h00, 8'h00, 8'hcc, 8'hcc, 8'h00, 8'h10};
    foreach (a[i]) begin
      i_tmdsrg_host.rd(a[i], d);
      check("reset value", e[i], d);
    end
    $display("reset values done");
  endtask
  task automatic t_fields();
    i_tmdsrg_host.wr(8'h04, 8'ha5);
    check("data term", 8'h05, {4'h0, data_term_sel});
    check("clk term", 8'h0a, {4'h0, clk_term_sel});
    i_tmdsrg_host.wr(8'h06, 8'h8f);
    check("drive", 8'h8f, {preemph_code, drive_code});
    i_tmdsrg_host.wr(8'h07, 8'h3a);
    i_tmdsrg_host.wr(8'h08, 8'h5f);
    check("eq ab", 8'h3a, eq_gain[7:0]);
    check("eq cd", 8'h5f, eq_gain[15:8]);
    i_tmdsrg_host.wr(8'h10, 8'h12);
    check("loop bw", 8'h02, {6'h00, loop_bw_sel});
    i_tmdsrg_host.rd(8'h10, d);
    check("loop bw read", 8'h12, d);
    i_tmdsrg_host.rd(8'h02, d);
    check("channel index", 8'h02, d);
    i_tmdsrg_host.rd(8'h30, d);
    check("unmapped", 8'h00, d);
    $display("register fields done");
  endtask
  task automatic t_outputs();
    rx_data = 3'h3;
    tick(5);
    check("tx true", 8'h03, {5'h00, tx_data_p});
    check("boost idle", 8'h00, {5'h00, preemph_on});
    i_tmdsrg_host.wr(8'h05, 8'h04);
    tick(1);
    check("tx inverted", 8'h04, {5'h00, tx_data_p});
    check("tx leg", 8'h03, {5'h00, tx_data_n});
    check("clk legs", 8'h01, {7'h00, tx_clk_p ^ tx_clk_n});
    i_tmdsrg_host.wr(8'h05, 8'h08);
    tick(1);
    check("tx reversed", 8'h06, {5'h00, tx_data_p});
    i_tmdsrg_host.wr(8'h05, 8'h03);
    check("both released", 8'h03, {6'h00, tx_data_oe_n, tx_clk_oe_n});
    i_tmdsrg_host.wr(8'h05, 8'h01);
    check("clk released", 8'h01, {6'h00, tx_data_oe_n, tx_clk_oe_n});
    i_tmdsrg_host.wr(8'h05, 8'h00);
    $display("output options done");
  endtask
  task automatic t_pattern(input logic [7:0] m);
    logic [39:0] s;
    int          bad = 0;
    i_tmdsrg_host.set_mode(m);
    tick(4);
    for (int i = 0; i < 40; i++) begin
      s[i] = tx_data_p[0];
      tick(1);
    end
    // each mode has its own recurrence; all zero would pass the prbs one
    for (int i = 7; i < 40; i++) begin
      case (m[1:0])
        2'h1: bad += int'(s[i] !== (s[i-6] ^ s[i-7]));
        2'h2: bad += int'(s[i] !== ~s[i-5]);
        default: bad += int'(s[i] !== ~s[i-1]);
      endcase
    end
    if (s == 40'h0) bad++;
    // every fast toggle bit follows a change, so all lanes boost
    if (m[1:0] == 2'h3) check("boost", 8'h07, {5'h00, preemph_on});
    check("pattern", 8'h00, 8'(bad));
    $display("pattern mode %h done", m);
  endtask
  task automatic t_errors();
    i_tmdsrg_host.set_mode(8'h00);
    rx_data = 3'h7;
    tick(20);
    i_tmdsrg_host.rd(8'h0a, d);
    check("count off", 8'h00, d);
    i_tmdsrg_host.wr(8'h09, 8'h04);
    tick(300);
    rx_data = 3'h0;
    tick(12);
    i_tmdsrg_host.rd(8'h0b, d);
    check("count sat", 8'hff, d);
    i_tmdsrg_host.rd(8'h0b, d);
    check("count clear", 8'h00, d);
    i_tmdsrg_host.rd(8'h0c, d);
    check("count lane2", 8'hff, d);
    i_tmdsrg_host.rd(8'h0a, d);
    check("count lane0", 8'hff, d);
    $display("error counting done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    rx_data = 3'h0;
    sel_chan = 2'h2;
    repeat (3) @(posedge core_clk);
    #1 nrst = 1'b1;
    t_reset();
    t_fields();
    t_outputs();
    t_pattern(8'h01);
    t_pattern(8'h02);
    t_pattern(8'h03);
    t_pattern(8'h01);
    t_errors();
    complete_run();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
endmodule

// *** dv/tmdsrg_host.sv ***
`timescale 1ns/1ps
// serial host model: one byte per access, bus shows no stale value when idle
module tmdsrg_host (
  input  wire logic       core_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  logic [7:0] mode_r = 8'h00;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // byte writes, callers keep bandwidth upper bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a; // released lines invert
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  task automatic set_mode(input logic [7:0] v);
    if (mode_r[1:0] == tmdsrg_pkg::MODE_HITOG) wr(tmdsrg_pkg::ADDR_PATGEN, 8'h00);
    wr(tmdsrg_pkg::ADDR_PATGEN, v);
    mode_r = v;
  endtask
endmodule

// *** rtl/tmdsrg_pkg.sv ***
package tmdsrg_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CHAN_CTRL  = 8'h02;
  localparam logic [7:0] ADDR_TERM_SEL   = 8'h04;
  localparam logic [7:0] ADDR_OUT_OPT    = 8'h05;
  localparam logic [7:0] ADDR_DRIVE      = 8'h06;
  localparam logic [7:0] ADDR_EQ_AB      = 8'h07;
  localparam logic [7:0] ADDR_EQ_CD      = 8'h08;
  localparam logic [7:0] ADDR_PATGEN     = 8'h09;
  localparam logic [7:0] ADDR_ERR_LINK0  = 8'h0a;
  localparam logic [7:0] ADDR_ERR_LINK2  = 8'h0c;
  localparam logic [7:0] ADDR_LOOP_BW    = 8'h10;
  // reset values, then the error count saturation value
  localparam logic [7:0] RST_TERM_SEL    = 8'h00;
  localparam logic [7:0] RST_OUT_OPT     = 8'h00;
  localparam logic [7:0] RST_DRIVE       = 8'h00;
  localparam logic [7:0] RST_EQ          = 8'hcc;
  localparam logic [7:0] RST_PATGEN      = 8'h00;
  localparam logic [7:0] RST_LOOP_BW     = 8'h10;
  localparam logic [7:0] ERR_SAT         = 8'hff;
  // output option bit positions
  localparam int OPT_CLK_TRI  = 0;
  localparam int OPT_DATA_TRI = 1;
  localparam int OPT_INVERT   = 2;
  localparam int OPT_REVERSE  = 3;
  // pattern generator fields
  localparam int PAT_ERR_EN   = 2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PRBS7  = 2'h1;
  localparam logic [1:0] MODE_LOWTOG = 2'h2;
  localparam logic [1:0] MODE_HITOG  = 2'h3;
  localparam logic [9:0] LOWTOG_WORD = 10'h01f; // 0000011111, sent msb first
  localparam logic [3:0] LOWTOG_LAST = 4'h9;
  localparam logic [6:0] PRBS_SEED   = 7'h7f;
endpackage

// *** rtl/tmdsrg_regs.sv ***
`timescale 1ns/1ps
module tmdsrg_regs #(
  parameter int LANES = 3
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  input  wire logic [1:0]       sel_chan,
  input  wire logic [LANES-1:0] rx_data,
  output logic      [LANES-1:0] tx_data_p,
  output logic      [LANES-1:0] tx_data_n,
  output logic                  tx_data_oe_n,
  output logic                  tx_clk_p,
  output logic                  tx_clk_n,
  output logic                  tx_clk_oe_n,
  output logic      [LANES-1:0] preemph_on,
  output logic      [3:0]       data_term_sel,
  output logic      [3:0]       clk_term_sel,
  output logic      [3:0]       drive_code,
  output logic      [3:0]       preemph_code,
  output logic      [15:0]      eq_gain,
  output logic      [1:0]       loop_bw_sel
);

  logic [7:0]       term_r;
  logic [7:0]       opt_r;
  logic [7:0]       drive_r;
  logic [7:0]       eq_ab_r;
  logic [7:0]       eq_cd_r;
  logic [7:0]       pat_r;
  logic [7:0]       bw_r;
  logic [7:0]       err_r [LANES];
  logic [LANES-1:0] rx_meta_r;
  logic [LANES-1:0] rx_sync_r;
  logic [LANES-1:0] mismatch;
  logic [6:0]       gen_r;
  logic [3:0]       tog_cnt_r;
  logic             hitog_r;
  logic [LANES-1:0] pat_bits;
  logic [LANES-1:0] ordered;
  logic [LANES-1:0] line_r;
  logic [LANES-1:0] prev_r;
  logic             clk_out_r;
  logic [7:0]       rd_val;
  logic [1:0]       mode;
  logic             err_en;

  assign mode   = pat_r[1:0];
  assign err_en = pat_r[tmdsrg_pkg::PAT_ERR_EN];

  // configuration writes; reserved loop bandwidth bits are stored as written
  // host register writes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      term_r  <= tmdsrg_pkg::RST_TERM_SEL;
      opt_r   <= tmdsrg_pkg::RST_OUT_OPT;
      drive_r <= tmdsrg_pkg::RST_DRIVE;
      eq_ab_r <= tmdsrg_pkg::RST_EQ;
      eq_cd_r <= tmdsrg_pkg::RST_EQ;
      pat_r   <= tmdsrg_pkg::RST_PATGEN;
      bw_r    <= tmdsrg_pkg::RST_LOOP_BW;
    end else if (reg_wr) begin
      case (reg_addr)
        tmdsrg_pkg::ADDR_TERM_SEL: term_r  <= reg_wdata;
        tmdsrg_pkg::ADDR_OUT_OPT:  opt_r   <= {4'h0, reg_wdata[3:0]};
        tmdsrg_pkg::ADDR_DRIVE:    drive_r <= reg_wdata;
        tmdsrg_pkg::ADDR_EQ_AB:    eq_ab_r <= reg_wdata;
        tmdsrg_pkg::ADDR_EQ_CD:    eq_cd_r <= reg_wdata;
        tmdsrg_pkg::ADDR_PATGEN:   pat_r   <= {5'h00, reg_wdata[2:0]};
        tmdsrg_pkg::ADDR_LOOP_BW:  bw_r    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // analog trims leave the block as plain levels straight from the registers
  // termination, drive, equalizer and loop bandwidth selects
  assign data_term_sel = term_r[3:0];
  assign clk_term_sel  = term_r[7:4];
  assign drive_code    = drive_r[3:0];
  assign preemph_code  = drive_r[7:4];
  assign eq_gain       = {eq_cd_r, eq_ab_r};
  assign loop_bw_sel   = bw_r[1:0];

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    case (reg_addr)
      tmdsrg_pkg::ADDR_CHAN_CTRL: rd_val = {6'h00, sel_chan};
      tmdsrg_pkg::ADDR_TERM_SEL:  rd_val = term_r;
      tmdsrg_pkg::ADDR_OUT_OPT:   rd_val = opt_r;
      tmdsrg_pkg::ADDR_DRIVE:     rd_val = drive_r;
      tmdsrg_pkg::ADDR_EQ_AB:     rd_val = eq_ab_r;
      tmdsrg_pkg::ADDR_EQ_CD:     rd_val = eq_cd_r;
      tmdsrg_pkg::ADDR_PATGEN:    rd_val = pat_r;
      tmdsrg_pkg::ADDR_LOOP_BW:   rd_val = bw_r;
      default: begin
        if (reg_addr >= tmdsrg_pkg::ADDR_ERR_LINK0 && reg_addr <= tmdsrg_pkg::ADDR_ERR_LINK2)
          rd_val = err_r[2'(reg_addr - tmdsrg_pkg::ADDR_ERR_LINK0)];
      end
    endcase
  end

  // read data is captured one edge after the strobe
  // registered read data for every address
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_val;
  end

  // recovered lane bits come from the cdr domain, so two flops first
  // retime onto pixel clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_meta_r <= '0;
      rx_sync_r <= '0;
    end else begin
      rx_meta_r <= rx_data;
      rx_sync_r <= rx_meta_r;
    end
  end

  // per lane self-synchronising checker and its saturating count
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [6:0] chk_r;
      assign mismatch[g] = rx_sync_r[g] != (chk_r[6] ^ chk_r[5]);
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
          chk_r <= tmdsrg_pkg::PRBS_SEED;
        else
          chk_r <= {chk_r[5:0], rx_sync_r[g]};
      end
      // an error in the clearing cycle is kept, so the count restarts at one
      // clear after read
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
          err_r[g] <= 8'h00;
        else if (reg_rd && reg_addr == tmdsrg_pkg::ADDR_ERR_LINK0 + 8'(g))
          err_r[g] <= {7'h00, err_en && mismatch[g]};
        else if (err_en && mismatch[g] && err_r[g] != tmdsrg_pkg::ERR_SAT)
          err_r[g] <= err_r[g] + 8'h01;
      end
    end
  endgenerate

  // pattern sources run freely so a mode change starts mid sequence
  // pattern generators
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gen_r     <= tmdsrg_pkg::PRBS_SEED;
      tog_cnt_r <= 4'h0;
      hitog_r   <= 1'b0;
    end else begin
      gen_r     <= {gen_r[5:0], gen_r[6] ^ gen_r[5]};
      tog_cnt_r <= (tog_cnt_r == tmdsrg_pkg::LOWTOG_LAST) ? 4'h0 : tog_cnt_r + 4'h1;
      hitog_r   <= ~hitog_r;
    end
  end

  // source select then lane order; all lanes carry the same test pattern
  always_comb begin
    case (mode)
      tmdsrg_pkg::MODE_NORMAL: pat_bits = rx_sync_r;
      tmdsrg_pkg::MODE_PRBS7:  pat_bits = {LANES{gen_r[6] ^ gen_r[5]}};
      tmdsrg_pkg::MODE_LOWTOG: pat_bits = {LANES{tmdsrg_pkg::LOWTOG_WORD[tmdsrg_pkg::LOWTOG_LAST - tog_cnt_r]}};
      tmdsrg_pkg::MODE_HITOG:  pat_bits = {LANES{hitog_r}};
      default:                 pat_bits = rx_sync_r;
    endcase
    ordered = pat_bits;
    if (opt_r[tmdsrg_pkg::OPT_REVERSE]) begin
      ordered[0] = pat_bits[2];
      ordered[2] = pat_bits[0];
    end
  end

  // output stage flops; prev_r lets the driver boost after each transition
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      line_r    <= '0;
      prev_r    <= '0;
      clk_out_r <= 1'b0;
    end else begin
      line_r    <= ordered;
      prev_r    <= line_r;
      clk_out_r <= ~clk_out_r;
    end
  end

  assign tx_data_p    = opt_r[tmdsrg_pkg::OPT_INVERT] ? ~line_r : line_r;
  assign tx_data_n    = ~tx_data_p;
  assign preemph_on   = (line_r ^ prev_r) & {LANES{preemph_code != 4'h0}};
  // forwarded clock keeps its polarity whatever the invert bit says
  assign tx_clk_p     = clk_out_r;
  assign tx_clk_n     = ~clk_out_r;
  assign tx_clk_oe_n  = opt_r[tmdsrg_pkg::OPT_CLK_TRI];
  assign tx_data_oe_n = opt_r[tmdsrg_pkg::OPT_DATA_TRI];

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // pin enables follow the stored option bits at all times
  a_data_release: assert property (tx_data_oe_n == opt_r[1] && tx_clk_oe_n == opt_r[0])
    else $error("output enables disagree with options");
  // the first edge after reset has no earlier toggle to compare against
  a_clk_polarity: assert property ($past(nrst)
    |-> tx_clk_p != tx_clk_n && tx_clk_p != $past(tx_clk_p))
    else $error("clock output not a clean toggle");
  // inversion acts on the data legs only
  a_invert_pair: assert property (opt_r[2] |-> tx_data_p == ~line_r)
    else $error("data inversion not applied");
  // outer lanes trade places one flop later
  a_lane_swap: assert property (opt_r[3] && $stable(opt_r) |=> line_r[0] == $past(pat_bits[2]))
    else $error("lane reversal missing");
  // middle lane keeps its place when the order is reversed
  a_lane_mid: assert property (opt_r[3] |=> line_r[1] == $past(pat_bits[1]))
    else $error("middle lane moved");
  // a disabled counter must not drift between reads
  a_count_hold: assert property (!err_en && !reg_rd |=> err_r[1] == $past(err_r[1]))
    else $error("count moved while disabled");
  // a full count sticks instead of wrapping to zero
  a_count_sat: assert property (err_r[0] == 8'hff && !reg_rd |=> err_r[0] == 8'hff)
    else $error("error count wrapped");
  // one error may land in the clearing cycle, so the count may restart at one
  a_read_clear: assert property (reg_rd && reg_addr == tmdsrg_pkg::ADDR_ERR_LINK0
    |=> reg_rdata == $past(err_r[0]) && err_r[0] <= 8'h01)
    else $error("error count not returned and cleared");
  // each bad bit adds exactly one below saturation
  a_count_step: assert property (err_en && mismatch[2] && !reg_rd && err_r[2] < 8'hff
    |=> err_r[2] == $past(err_r[2]) + 8'h01)
    else $error("mismatch not counted");
  // fast toggle flips every bit time
  a_hitog_alt: assert property (mode == 2'h3 ##1 mode == 2'h3 |-> pat_bits[1] != $past(pat_bits[1]))
    else $error("fast toggle not alternating");
  // both equalizer bytes come out of reset at their default gain
  a_eq_default: assert property ($rose(nrst) |-> eq_gain == 16'hcccc)
    else $error("equalizer reset value wrong");
  // option writes reach the clock and data pin enables on the next edge
  a_opt_write: assert property (reg_wr && reg_addr == tmdsrg_pkg::ADDR_OUT_OPT
    |=> {tx_data_oe_n, tx_clk_oe_n} == $past(reg_wdata[1:0]))
    else $error("option write not applied to pin enables");
  // the clock half of the byte lands in the upper nibble
  a_term_write: assert property (reg_wr && reg_addr == tmdsrg_pkg::ADDR_TERM_SEL
    |=> {clk_term_sel, data_term_sel} == $past(reg_wdata))
    else $error("termination write not applied");
  // drive and pre-emphasis codes leave exactly as written
  a_drive_write: assert property (reg_wr && reg_addr == tmdsrg_pkg::ADDR_DRIVE
    |=> {preemph_code, drive_code} == $past(reg_wdata))
    else $error("drive write not applied");
  // boost only in the bit after a change, and never with a zero code
  a_boost_edge: assert property (preemph_on[0] == (preemph_code != 4'h0 && line_r[0] != $past(line_r[0])))
    else $error("pre-emphasis on wrong bit");
  // second equalizer byte drives the upper half of the gain bus
  a_eq_write: assert property (reg_wr && reg_addr == tmdsrg_pkg::ADDR_EQ_CD
    |=> eq_gain[15:8] == $past(reg_wdata))
    else $error("equalizer write not applied");
  // only the low two bits steer the loop, the rest are just stored
  a_bw_write: assert property (reg_wr && reg_addr == tmdsrg_pkg::ADDR_LOOP_BW
    |=> loop_bw_sel == $past(reg_wdata[1:0]))
    else $error("loop bandwidth write not applied");
  // channel readback reflects the selector as it stood at the strobe
  a_chan_read: assert property (reg_rd && reg_addr == tmdsrg_pkg::ADDR_CHAN_CTRL
    |=> reg_rdata == {6'h00, $past(sel_chan)})
    else $error("channel index readback wrong");
  // in normal mode the output flop carries the synchronised lane bits
  a_retime_path: assert property (mode == tmdsrg_pkg::MODE_NORMAL && !opt_r[3]
    |=> line_r == $past(rx_sync_r))
    else $error("lane not retimed straight through");
  // read data must not move without a read strobe
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

endmodule
